// ==== particle_count_sequencer_tb_top.sv ====
// Testbench joining both ends of the particle count sequencer
`timescale 1ns/10ps
module particle_count_sequencer_tb_top import pcs_pkg::*;;
  localparam logic [1:0] MAGS [8] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
  // Squib pulse length of the device's default setting
  localparam int SQUIB_LEN = 1000;
  logic ref_clk, sys_rst, thermostat_call, hwrite, hreadyout, hresp, hsel;
  logic [2:0] hsize;
  logic defl_neg, analyzer_b, gates_open, test_osc_en, test_osc_out, heater_on, squib_fire, auto_frozen;
  logic [11:0] det_pulse;
  logic [2:0] step_pos;
  logic [1:0] defl_mag, htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int n_mismatch, n_tests;
  int sq_len = 0;

  pcs_link_if link();
  pcs_device #(.CLR_CYC(20), .ENA_CYC(400)) pcs_device_inst (.ref_clk, .sys_rst, .link(link.dev),
    .det_pulse, .thermostat_call, .step_pos, .defl_neg, .defl_mag, .analyzer_b, .gates_open, .test_osc_en,
    .test_osc_out, .heater_on, .squib_fire, .auto_frozen);
  pcs_host #(.SHIFT_HALF(8), .CMD_HOLD(8), .BACKUP_FRAMES(2)) pcs_host_inst (.ref_clk, .sys_rst,
    .link(link.host), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata);
  pcs_properties pcs_properties_inst (.ref_clk, .sys_rst,
    .frame_mark(link.frame_mark), .shift_pulse(link.shift_pulse), .data_demand(link.data_demand),
    .ser_data(link.ser_data), .cmd_strobe(link.cmd_strobe), .cmd_code(link.cmd_code));

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (squib_fire === 1'h1) sq_len <= sq_len + 1;
  end

  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic fail;
    n_mismatch++;
    give_verdict();
  endtask : fail

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic sig(input int s);
    case (s)
      0: return gates_open;
      1: return link.frame_mark;
      2: return link.cmd_strobe;
      3: return test_osc_out;
      default: return squib_fire;
    endcase
  endfunction : sig

  task automatic wait_sig(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (sig(s) !== v) begin
      @(posedge ref_clk);
      k++;
      if (k > lim) fail();
    end
  endtask : wait_sig

  task automatic hold;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
      if (k > 50) fail();
    end while (hreadyout !== 1'h1);
  endtask : hold

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hold();
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    rd = hrdata;
  endtask : ahb

  task automatic send_cmd(input logic [3:0] c);
    wait_sig(2, 1'h0, 100);
    ahb(1'h1, HREG_CMD, {28'h0, c});
    wait_sig(2, 1'h1, 20);
    wait_sig(2, 1'h0, 20);
    repeat (4) @(posedge ref_clk);
  endtask : send_cmd

  task automatic t_reset;
    chk(step_pos, 3'h0);
    chk({gates_open, squib_fire, auto_frozen, hreadyout, hresp}, 5'h2);
    ahb(1'h1, 8'h40, 32'h1234_5678);
    ahb(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'h0, HREG_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_heat;
    repeat (6) @(posedge ref_clk);
    chk(heater_on, 1'h1);
    thermostat_call <= 1'h0;
    repeat (6) @(posedge ref_clk);
    chk(heater_on, 1'h0);
    send_cmd(CMD_HEAT_ON);
    chk(heater_on, 1'h1);
    send_cmd(CMD_HEAT_OFF);
    thermostat_call <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk(heater_on, 1'h0);
    ahb(1'h0, HREG_CMD, 32'h0);
    chk(rd, 32'h2);
    send_cmd(CMD_STEP);
    chk({auto_frozen, step_pos}, 4'h0);
  endtask : t_heat

  task automatic t_count;
    logic an;
    logic [2:0] pos, p2;
    logic [5:0] mine, other;
    logic [3:0] tags;
    int k;
    ahb(1'h1, HREG_CTRL, 32'h1);
    wait_sig(1, 1'h1, 25000);
    k = 0;
    while (gates_open !== 1'h1 && k < 500) begin
      @(posedge ref_clk);
      k++;
    end
    chk(k >= 400 && k <= 410, 1'h1);
    an = analyzer_b;
    pos = step_pos;
    // Detector i gets i+1 pulses, idle analyzer two each
    for (int p = 0; p < 6; p++) begin
      mine = 6'h3f << p;
      other = p < 2 ? 6'h3f : 6'h0;
      det_pulse <= an ? {mine, other} : {other, mine};
      repeat (3) @(posedge ref_clk);
      det_pulse <= 12'h0;
      repeat (3) @(posedge ref_clk);
    end
    wait_sig(0, 1'h0, 25000);
    wait_sig(0, 1'h1, 1000);
    p2 = an ? pos + 3'h1 : pos;
    chk({analyzer_b, step_pos}, {~an, p2});
    send_cmd(CMD_AUTO_OFF);
    chk(auto_frozen, 1'h1);
    wait_sig(0, 1'h0, 25000);
    tags = {MAGS[pos][0], MAGS[pos][1], pos >= 3'h4 && pos <= 3'h6, an};
    for (int i = 0; i < 6; i++) begin
      ahb(1'h0, HREG_DATA0 + 8'(i * HREG_STRIDE), 32'h0);
      chk(rd, 32'(i + 1) | (i < 4 ? 32'(tags[i]) << 19 : 32'h0));
    end
    // Two full frame pairs read out since run began
    ahb(1'h0, HREG_STEPS, 32'h0);
    chk(rd, 32'h2);
    wait_sig(0, 1'h1, 1000);
    chk({analyzer_b, step_pos}, {an, p2});
  endtask : t_count

  task automatic t_freeze;
    logic [2:0] p;
    p = step_pos;
    for (int k = 0; k < 8; k++) begin
      p = p + 3'h1;
      send_cmd(CMD_STEP);
      chk(step_pos, p);
      chk({defl_neg, defl_mag}, {p >= 3'h4 && p <= 3'h6, MAGS[p]});
      chk(test_osc_en, p == 3'h7);
      if (p == 3'h7) begin
        wait_sig(3, 1'h1, 800);
        chk(test_osc_out, 1'h1);
      end
    end
    send_cmd(CMD_AUTO_ON);
    chk(auto_frozen, 1'h0);
  endtask : t_freeze

  task automatic t_cover;
    int k;
    k = 0;
    do begin
      ahb(1'h0, HREG_STATUS, 32'h0);
      k++;
      if (k > 20000) fail();
    end while (rd[2] !== 1'h1);
    chk(rd[2:1], 2'h3);
    k = 0;
    while (squib_fire !== 1'h0 || sq_len == 0) begin
      @(posedge ref_clk);
      k++;
      if (k > 1500) fail();
    end
    chk(sq_len, SQUIB_LEN);
  endtask : t_cover

  initial begin
    sys_rst = 1'h1;
    det_pulse = 12'h0;
    thermostat_call = 1'h1;
    htrans = 2'h0;
    hsel = 1'h0;
    hsize = 3'h0;
    haddr = 32'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_reset();
    t_heat();
    t_count();
    t_freeze();
    t_cover();
    give_verdict();
  end
endmodule : particle_count_sequencer_tb_top

// ==== pcs_counter.sv ====
// Detector pulse counter with synchronous clear
`timescale 1ns/10ps
module pcs_counter #(
  parameter int W = 19
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic inc,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } pcs_cnt_t;
  pcs_cnt_t st_reg;
  pcs_cnt_t st_next;

  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next.cnt = '0;
    end else if (inc) begin
      st_next.cnt = st_reg.cnt + 1'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.cnt;
endmodule : pcs_counter

// ==== pcs_device.sv ====
// Device end: deflection step sequencer, gated counters, serial readout
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - Step deflection through seven levels incl. zero
// - Even frame mark is the step tick
// - Sequence may start at any position
// - Count A, then B, then next level
// - Other analyzer's result stays readable meanwhile
// - Frame mark blocks counters, loads tag bits
// - First shift loads counts; falling edge steps
// - Clear counters 30 ms after step
// - Reopen gates 60 ms after mark
// - Twelve gates route detectors to counters
// - Detectors 5,6 twenty bits, others nineteen
// - Tag bit extends each 19-bit word
// - Tags give analyzer, polarity, magnitude
// - Data demand gates serial shift-out
// - Frame has 64 words, six ours
// - Words 7/17,19/23,39/55 carry detector pairs
// - Test oscillator on every other zero
// - Oscillator counts like detector pulses
// - Heater auto at reset; 1 on, 2 off
// - Command 3 fires squibs; backup timer too
// - Command 6 freezes step, 4 resumes
// - Command 5 steps manually while frozen
module pcs_device
  import pcs_pkg::*;
#(
  parameter int CLR_CYC = CLR_DELAY_CYC,
  parameter int ENA_CYC = ENA_DELAY_CYC,
  parameter int SQUIB_CYC = 1000,
  parameter logic [2:0] START_POS = 3'h0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  pcs_link_if.dev link,
  input wire logic [N_GATE-1:0] det_pulse,
  input wire logic thermostat_call,
  output logic [2:0] step_pos,
  output logic defl_neg,
  output logic [1:0] defl_mag,
  output logic analyzer_b,
  output logic gates_open,
  output logic test_osc_en,
  output logic test_osc_out,
  output logic heater_on,
  output logic squib_fire,
  output logic auto_frozen
);
  typedef struct packed {
    logic [1:0] fm_s;
    logic [1:0] sh_s;
    logic [1:0] dd_s;
    logic [1:0] cs_s;
    logic [1:0] th_s;
    logic [3:0] code_s0;
    logic [3:0] code_s1;
    logic fm_d;
    logic sh_d;
    logic cs_d;
    logic [N_GATE-1:0] det_s0;
    logic [N_GATE-1:0] det_s1;
    logic [N_GATE-1:0] det_d;
    logic gates_open;
    logic analyzer_b;
    logic load_pend;
    logic adv_pend;
    logic [2:0] pos;
    logic frozen;
    logic clr_run;
    logic ena_run;
    logic [31:0] clr_cnt;
    logic [31:0] ena_cnt;
    logic [3:0] tag;
    logic [SREG_W-1:0] sreg;
    logic ser;
    pcs_heat_t heat;
    logic heater;
    logic [31:0] squib_cnt;
    logic squib;
    logic test_en;
    logic [15:0] osc_cnt;
    logic osc;
    logic osc_d;
    logic defl_neg;
    logic [1:0] defl_mag;
  } pcs_dev_t;

  pcs_dev_t st_reg;
  pcs_dev_t st_next;
  logic fm_rise;
  logic sh_rise;
  logic sh_fall;
  logic cs_rise;
  logic cnt_clr;
  logic [N_GATE-1:0] hit;
  logic [N_DET-1:0] cnt_inc;
  logic [WORD_W-1:0] word;
  logic [SREG_W-1:0] load_word;
  wire logic [WORD_W-1:0] cnt_w [N_DET];

  for (genvar i = 0; i < N_DET; i++) begin : g_cnt
    localparam int W = (i >= HI_DET_FIRST) ? CNT_W_HI : CNT_W_LO;
    pcs_counter #(.W(W)) u_cnt (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clr(cnt_clr),
      .inc(cnt_inc[i]),
      .count(cnt_w[i][W-1:0])
    );
    if (W < WORD_W) begin : g_pad
      assign cnt_w[i][WORD_W-1:W] = '0;
    end
  end

  always_comb begin
    st_next = st_reg;
    cnt_clr = 1'h0;
    word = '0;
    load_word = '0;
    st_next.fm_s = {st_reg.fm_s[0], link.frame_mark};
    st_next.sh_s = {st_reg.sh_s[0], link.shift_pulse};
    st_next.dd_s = {st_reg.dd_s[0], link.data_demand};
    st_next.cs_s = {st_reg.cs_s[0], link.cmd_strobe};
    st_next.th_s = {st_reg.th_s[0], thermostat_call};
    st_next.code_s0 = link.cmd_code;
    st_next.code_s1 = st_reg.code_s0;
    st_next.det_s0 = det_pulse;
    st_next.det_s1 = st_reg.det_s0;
    st_next.fm_d = st_reg.fm_s[1];
    st_next.sh_d = st_reg.sh_s[1];
    st_next.cs_d = st_reg.cs_s[1];
    st_next.det_d = st_reg.det_s1;
    st_next.osc_d = st_reg.osc;
    fm_rise = st_reg.fm_s[1] && !st_reg.fm_d;
    sh_rise = st_reg.sh_s[1] && !st_reg.sh_d;
    sh_fall = !st_reg.sh_s[1] && st_reg.sh_d;
    cs_rise = st_reg.cs_s[1] && !st_reg.cs_d;

    // Detector and oscillator pulses into the selected analyzer's counters
    hit = (st_reg.det_s1 & ~st_reg.det_d) | {N_GATE{st_reg.osc && !st_reg.osc_d}};
    cnt_inc = '0;
    if (st_reg.gates_open) begin
      cnt_inc = st_reg.analyzer_b ? hit[N_GATE-1:N_DET] : hit[N_DET-1:0];
    end

    for (int i = 0; i < N_DET; i++) begin
      word = cnt_w[i];
      if (i < HI_DET_FIRST) begin
        word[WORD_W-1] = st_reg.tag[i];
      end
      load_word[SREG_W-1-i*WORD_W -: WORD_W] = word;
    end

    if (st_reg.clr_run) begin
      st_next.clr_cnt = st_reg.clr_cnt + 32'h0000_0001;
      if (st_reg.clr_cnt == 32'(CLR_CYC - 1)) begin
        cnt_clr = 1'h1;
        st_next.clr_run = 1'h0;
      end
    end
    if (st_reg.ena_run) begin
      st_next.ena_cnt = st_reg.ena_cnt + 32'h0000_0001;
      if (st_reg.ena_cnt == 32'(ENA_CYC - 1)) begin
        st_next.gates_open = 1'h1;
        st_next.ena_run = 1'h0;
      end
    end

    // Even frame mark closes the gates, latches the tags and starts the reopen timer
    if (fm_rise) begin
      st_next.gates_open = 1'h0;
      st_next.tag = {st_reg.defl_mag[0], st_reg.defl_mag[1], st_reg.defl_neg, st_reg.analyzer_b};
      st_next.load_pend = 1'h1;
      st_next.ena_run = 1'h1;
      st_next.ena_cnt = '0;
    end

    // Loaded word set shifts out while the other analyzer counts
    if (sh_rise && st_reg.load_pend) begin
      st_next.sreg = load_word;
      st_next.load_pend = 1'h0;
      st_next.adv_pend = 1'h1;
    end else if (sh_fall && st_reg.adv_pend) begin
      st_next.adv_pend = 1'h0;
      st_next.analyzer_b = !st_reg.analyzer_b;
      if (st_reg.analyzer_b && !st_reg.frozen) begin
        st_next.pos = st_reg.pos + 3'h1;
      end
      st_next.clr_run = 1'h1;
      st_next.clr_cnt = '0;
    end else if (sh_fall && st_reg.dd_s[1] && !st_reg.load_pend) begin
      st_next.sreg = {st_reg.sreg[SREG_W-2:0], 1'h0};
    end

    if (st_reg.squib_cnt != '0) begin
      st_next.squib_cnt = st_reg.squib_cnt - 32'h0000_0001;
    end
    if (cs_rise) begin
      case (st_reg.code_s1)
        CMD_HEAT_ON: st_next.heat = PCS_HEAT_ON;
        CMD_HEAT_OFF: st_next.heat = PCS_HEAT_OFF;
        CMD_COVER: st_next.squib_cnt = 32'(SQUIB_CYC);
        CMD_AUTO_ON: st_next.frozen = 1'h0;
        CMD_AUTO_OFF: st_next.frozen = 1'h1;
        CMD_STEP: begin
          if (st_reg.frozen) begin
            st_next.pos = st_next.pos + 3'h1;
          end
        end
        default: begin
        end
      endcase
    end
    st_next.squib = st_next.squib_cnt != '0;
    case (st_next.heat)
      PCS_HEAT_ON: st_next.heater = 1'h1;
      PCS_HEAT_OFF: st_next.heater = 1'h0;
      default: st_next.heater = st_reg.th_s[1];
    endcase

    // Second zero position of each cycle runs the test oscillator
    st_next.test_en = st_next.pos == POS_ZERO_TEST;
    if (!st_reg.test_en) begin
      st_next.osc_cnt = '0;
      st_next.osc = 1'h0;
    end else if (st_reg.osc_cnt == 16'(TEST_OSC_HALF - 1)) begin
      st_next.osc_cnt = '0;
      st_next.osc = !st_reg.osc;
    end else begin
      st_next.osc_cnt = st_reg.osc_cnt + 16'h0001;
    end

    st_next.ser = st_next.sreg[SREG_W-1];
    st_next.defl_neg = pcs_pos_neg(st_next.pos);
    st_next.defl_mag = pcs_pos_mag(st_next.pos);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.pos <= START_POS;
      st_reg.defl_neg <= pcs_pos_neg(START_POS);
      st_reg.defl_mag <= pcs_pos_mag(START_POS);
      st_reg.test_en <= START_POS == POS_ZERO_TEST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.ser_data = st_reg.ser;
  assign step_pos = st_reg.pos;
  assign defl_neg = st_reg.defl_neg;
  assign defl_mag = st_reg.defl_mag;
  assign analyzer_b = st_reg.analyzer_b;
  assign gates_open = st_reg.gates_open;
  assign test_osc_en = st_reg.test_en;
  assign test_osc_out = st_reg.osc;
  assign heater_on = st_reg.heater;
  assign squib_fire = st_reg.squib;
  assign auto_frozen = st_reg.frozen;
endmodule : pcs_device

// ==== pcs_host.sv ====
// Data subsystem end: frame timing, readout capture, commands, AHB-Lite registers
`timescale 1ns/10ps
module pcs_host
  import pcs_pkg::*;
#(
  parameter int SHIFT_HALF = 16,
  parameter int CMD_HOLD = 64,
  parameter int BACKUP_FRAMES = 1000
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  pcs_link_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  typedef struct packed {
    logic run;
    logic [15:0] div;
    logic ph;
    logic [3:0] bit_idx;
    logic [5:0] word;
    logic frame_odd;
    logic mark;
    logic shift;
    logic demand;
    logic [1:0] sd_s;
    logic [WORD_W-1:0] acc;
    logic [N_DET-1:0][WORD_W-1:0] data;
    logic [15:0] steps;
    logic [15:0] even_frames;
    logic [3:0] cmd_code;
    logic cmd_strobe;
    logic [15:0] cmd_cnt;
    logic cover_sent;
    logic backup_fired;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } pcs_host_t;

  pcs_host_t st_reg;
  pcs_host_t st_next;
  logic [2:0] slot;
  logic [2:0] det;
  logic [31:0] rd;

  always_comb begin
    st_next = st_reg;
    rd = 32'h0000_0000;
    slot = pcs_word_slot(st_reg.word);
    det = 3'(st_reg.frame_odd ? DET_PER_FRAME : 0) + 3'(slot >> 1);
    st_next.sd_s = {st_reg.sd_s[0], link.ser_data};

    // Address phase: read data is registered for the data phase
    case (haddr[7:0])
      HREG_CTRL: rd = {31'h0000_0000, st_reg.run};
      HREG_CMD: rd = {28'h000_0000, st_reg.cmd_code};
      HREG_STATUS: rd = {29'h0000_0000, st_reg.backup_fired, st_reg.cover_sent, st_reg.cmd_strobe};
      HREG_STEPS: rd = {16'h0000, st_reg.steps};
      default: begin
        for (int i = 0; i < N_DET; i++) begin
          if (haddr[7:0] == 8'(HREG_DATA0 + HREG_STRIDE * i)) begin
            rd = 32'(st_reg.data[i]);
          end
        end
      end
    endcase
    st_next.rdata = rd;
    st_next.ap_wr = hsel && hready && htrans[1] && hwrite;
    st_next.ap_addr = haddr[7:0];

    if (st_reg.cmd_strobe) begin
      st_next.cmd_cnt = st_reg.cmd_cnt + 16'h0001;
      if (st_reg.cmd_cnt == 16'(CMD_HOLD - 1)) begin
        st_next.cmd_strobe = 1'h0;
      end
    end
    if (st_reg.ap_wr) begin
      case (st_reg.ap_addr)
        HREG_CTRL: st_next.run = hwdata[0];
        HREG_CMD: begin
          if (!st_reg.cmd_strobe) begin
            st_next.cmd_code = hwdata[3:0];
            st_next.cmd_strobe = 1'h1;
            st_next.cmd_cnt = '0;
            if (hwdata[3:0] == CMD_COVER) begin
              st_next.cover_sent = 1'h1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Frame of 64 ten-bit words, one bit slot is two half periods
    if (!st_reg.run) begin
      st_next.div = '0;
      st_next.ph = 1'h0;
      st_next.bit_idx = '0;
      st_next.word = '0;
      st_next.frame_odd = 1'h0;
    end else if (st_reg.div == 16'(SHIFT_HALF - 1)) begin
      st_next.div = '0;
      st_next.ph = !st_reg.ph;
      if (!st_reg.ph) begin
        if (slot != NO_SLOT) begin
          st_next.acc = {st_reg.acc[WORD_W-2:0], st_reg.sd_s[1]};
        end
      end else if (st_reg.bit_idx == 4'(TM_WORD_BITS - 1)) begin
        st_next.bit_idx = '0;
        if (slot != NO_SLOT && slot[0]) begin
          st_next.data[det] = st_reg.acc;
          if (st_reg.frame_odd && slot == LAST_SLOT) begin
            st_next.steps = st_reg.steps + 16'h0001;
          end
        end
        if (st_reg.word == 6'(TM_FRAME_WORDS - 1)) begin
          st_next.word = '0;
          st_next.frame_odd = !st_reg.frame_odd;
          if (st_reg.frame_odd && st_reg.even_frames != 16'hFFFF) begin
            st_next.even_frames = st_reg.even_frames + 16'h0001;
          end
        end else begin
          st_next.word = st_reg.word + 6'h01;
        end
      end else begin
        st_next.bit_idx = st_reg.bit_idx + 4'h1;
      end
    end else begin
      st_next.div = st_reg.div + 16'h0001;
    end

    // Backup cover release when no command 3 was sent in time
    // Strobe must drop first so the device sees a fresh rising edge
    if (st_reg.even_frames >= 16'(BACKUP_FRAMES) && !st_reg.cover_sent && !st_reg.cmd_strobe &&
        !st_next.cmd_strobe) begin
      st_next.cmd_code = CMD_COVER;
      st_next.cmd_strobe = 1'h1;
      st_next.cmd_cnt = '0;
      st_next.cover_sent = 1'h1;
      st_next.backup_fired = 1'h1;
    end

    st_next.shift = st_next.run && !st_next.ph && (st_next.word != 6'h00);
    st_next.mark = st_next.run && (st_next.word == 6'h00) && !st_next.frame_odd;
    st_next.demand = st_next.run && (pcs_word_slot(st_next.word) != NO_SLOT);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.ready <= 1'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.frame_mark = st_reg.mark;
  assign link.shift_pulse = st_reg.shift;
  assign link.data_demand = st_reg.demand;
  assign link.cmd_strobe = st_reg.cmd_strobe;
  assign link.cmd_code = st_reg.cmd_code;
  assign hreadyout = st_reg.ready;
  assign hresp = st_reg.resp;
  assign hrdata = st_reg.rdata;
endmodule : pcs_host

// ==== pcs_link_if.sv ====
// Link between the sequencer and the telemetry data subsystem
`timescale 1ns/10ps
interface pcs_link_if;
  logic frame_mark;
  logic shift_pulse;
  logic data_demand;
  logic ser_data;
  logic cmd_strobe;
  logic [3:0] cmd_code;
  modport dev (input frame_mark, input shift_pulse, input data_demand, input cmd_strobe, input cmd_code,
    output ser_data);
  modport host (output frame_mark, output shift_pulse, output data_demand, output cmd_strobe,
    output cmd_code, input ser_data);
endinterface : pcs_link_if

// ==== pcs_pkg.sv ====
// Shared constants, types and helpers of the particle count sequencer
package pcs_pkg;
  localparam int REF_CLK_KHZ = 250000;
  localparam int CLR_DELAY_MS = 30;
  localparam int ENA_DELAY_MS = 60;
  localparam int CLR_DELAY_CYC = CLR_DELAY_MS * REF_CLK_KHZ;
  localparam int ENA_DELAY_CYC = ENA_DELAY_MS * REF_CLK_KHZ;
  localparam int TEST_OSC_KHZ = 350;
  localparam int TEST_OSC_HALF = REF_CLK_KHZ / (2 * TEST_OSC_KHZ);
  localparam int N_DET = 6;
  localparam int N_GATE = 12;
  localparam int HI_DET_FIRST = 4;
  localparam int DET_PER_FRAME = 3;
  localparam int CNT_W_HI = 20;
  localparam int CNT_W_LO = 19;
  localparam int WORD_W = 20;
  localparam int SREG_W = 120;
  localparam int TM_WORD_BITS = 10;
  localparam int TM_FRAME_WORDS = 64;
  localparam logic [2:0] POS_ZERO_TEST = 3'h7;
  localparam logic [2:0] NO_SLOT = 3'h7;
  localparam logic [2:0] LAST_SLOT = 3'h5;
  localparam logic [3:0] CMD_HEAT_ON = 4'h1;
  localparam logic [3:0] CMD_HEAT_OFF = 4'h2;
  localparam logic [3:0] CMD_COVER = 4'h3;
  localparam logic [3:0] CMD_AUTO_ON = 4'h4;
  localparam logic [3:0] CMD_STEP = 4'h5;
  localparam logic [3:0] CMD_AUTO_OFF = 4'h6;
  localparam logic [1:0] MAG_0 = 2'h0;
  localparam logic [1:0] MAG_35 = 2'h1;
  localparam logic [1:0] MAG_350 = 2'h2;
  localparam logic [1:0] MAG_3500 = 2'h3;
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_CMD = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam logic [7:0] HREG_STEPS = 8'h0C;
  localparam logic [7:0] HREG_DATA0 = 8'h10;
  localparam int HREG_STRIDE = 4;
  typedef enum logic [1:0] {PCS_HEAT_AUTO, PCS_HEAT_ON, PCS_HEAT_OFF} pcs_heat_t;

  // Order: +3500 +350 +35 background -3500 -350 -35 test
  function automatic logic [1:0] pcs_pos_mag(input logic [2:0] pos);
    case (pos)
      3'h0, 3'h4: return MAG_3500;
      3'h1, 3'h5: return MAG_350;
      3'h2, 3'h6: return MAG_35;
      default: return MAG_0;
    endcase
  endfunction : pcs_pos_mag

  function automatic logic pcs_pos_neg(input logic [2:0] pos);
    return pos[2] && (pos != POS_ZERO_TEST);
  endfunction : pcs_pos_neg

  // Telemetry words 7 17 19 23 39 55
  function automatic logic [2:0] pcs_word_slot(input logic [5:0] w);
    case (w)
      6'h07: return 3'h0;
      6'h11: return 3'h1;
      6'h13: return 3'h2;
      6'h17: return 3'h3;
      6'h27: return 3'h4;
      6'h37: return 3'h5;
      default: return NO_SLOT;
    endcase
  endfunction : pcs_word_slot
endpackage : pcs_pkg

// ==== pcs_properties.sv ====
// Link protocol checks between the sequencer and the telemetry host
`timescale 1ns/10ps
module pcs_properties
  import pcs_pkg::*;
#(
  parameter int SHIFT_HALF = 8,
  parameter int CMD_HOLD = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic frame_mark,
  input wire logic shift_pulse,
  input wire logic data_demand,
  input wire logic ser_data,
  input wire logic cmd_strobe,
  input wire logic [3:0] cmd_code
);
  localparam int WORD_CYC = 2 * TM_WORD_BITS * SHIFT_HALF;
  int mark_cnt, shift_cnt, dem_cnt, cmd_cnt, gap_cnt;
  logic seen;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Run lengths of link levels and spacing of marks
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mark_cnt <= 0;
      shift_cnt <= 0;
      dem_cnt <= 0;
      cmd_cnt <= 0;
      gap_cnt <= 0;
      seen <= 1'h0;
    end else begin
      mark_cnt <= frame_mark ? mark_cnt + 1 : 0;
      shift_cnt <= shift_pulse ? shift_cnt + 1 : 0;
      dem_cnt <= data_demand ? dem_cnt + 1 : 0;
      cmd_cnt <= cmd_strobe ? cmd_cnt + 1 : 0;
      gap_cnt <= $rose(frame_mark) ? 1 : gap_cnt + 1;
      seen <= seen | $rose(frame_mark);
    end
  end

  // First eight cycles of the mark word carry no shifts and no demand
  sequence s_quiet;
    (!shift_pulse && !data_demand) [*8];
  endsequence

  // Low half of a shift pulse, eight cycles here
  sequence s_low_half;
    !shift_pulse [*8];
  endsequence

  mark_len_a: assert property ($fell(frame_mark) |-> mark_cnt == WORD_CYC)
    else $error("frame mark width wrong");
  mark_gap_a: assert property ($rose(frame_mark) && seen |-> gap_cnt == 2 * TM_FRAME_WORDS * WORD_CYC)
    else $error("even frame mark spacing wrong");
  mark_quiet_a: assert property ($rose(frame_mark) |-> s_quiet)
    else $error("shift or demand during mark word");
  shift_len_a: assert property ($fell(shift_pulse) |-> shift_cnt == SHIFT_HALF)
    else $error("shift high half wrong");
  shift_low_a: assert property ($fell(shift_pulse) |-> s_low_half)
    else $error("shift low half too short");
  demand_len_a: assert property ($fell(data_demand) |-> dem_cnt == WORD_CYC)
    else $error("data demand not one word long");
  ser_hold_a: assert property (shift_pulse && $past(shift_pulse) && data_demand |-> $stable(ser_data))
    else $error("serial data moved while sampled");
  cmd_hold_a: assert property ($fell(cmd_strobe) |-> cmd_cnt == CMD_HOLD)
    else $error("command strobe width wrong");
  cmd_code_a: assert property (cmd_strobe && $past(cmd_strobe) |-> $stable(cmd_code))
    else $error("command code moved under strobe");
endmodule : pcs_properties
